// [verilog/sbfp_defs.vh]
// constants for the serial bootloader flash programmer
`ifndef SBFP_DEFS_VH
`define SBFP_DEFS_VH
// timing: system clock period in ns and serial clock half period in system cycles
`define SBFP_CLK_NS 10
`define SBFP_SPI_HALF 4'h8
// device reset low 1 us, wait after reset 2 us, status gap 2 us, in system cycles
`define SBFP_RST_CYC 16'h0064
`define SBFP_RWAIT_CYC 16'h00C8
`define SBFP_GAP_CYC 16'h00C8
// select high time between frames, one serial half period
`define SBFP_CSHI_CYC 16'h0008
`define SBFP_MISO_WAIT_US 100
// image layout
`define SBFP_LAST_PAGE 5'h1E
`define SBFP_RAM_ADDR 16'h6000
`define SBFP_FLASH_BASE 16'h8000
`define SBFP_PAGE_BYTES 11'h400
`define SBFP_CNT_OFS 11'h010
// command internal codes
`define SBFP_C_BOOT 4'h0
`define SBFP_C_UNLOCK 4'h1
`define SBFP_C_ERASE 4'h2
`define SBFP_C_SETADDR 4'h3
`define SBFP_C_WRITE 4'h4
`define SBFP_C_PROG 4'h5
`define SBFP_C_VERIFY 4'h6
`define SBFP_C_RESTART 4'h7
`define SBFP_C_STATUS 4'h8
// command opcodes on the wire
`define SBFP_OP_BOOT0 8'hB0
`define SBFP_OP_BOOT1 8'h00
`define SBFP_OP_UNLOCK 8'hB1
`define SBFP_OP_ERASE 8'hB2
`define SBFP_OP_SETADDR 8'hB3
`define SBFP_OP_WRITE 8'hB4
`define SBFP_OP_PROG 8'hB5
`define SBFP_OP_VERIFY 8'hB6
`define SBFP_OP_RESTART 8'hB7
`define SBFP_OP_STATUS 8'hB8
// expected status words
`define SBFP_SW_OK 16'h8000
`define SBFP_SW_BUSY 16'h0000
`endif

// [verilog/sbfp_programmer.v]
// host sequencer that programs an image through the serial bootloader
`timescale 1ns/100ps
`include "sbfp_defs.vh"

module sbfp_programmer #(
  parameter integer MISO_WAIT_US = `SBFP_MISO_WAIT_US
) (
  // clock and reset
  input wire mclk_in,
  input wire resetn_in,
  // control
  input wire start_in,
  output wire busy_out,
  output reg done_out,
  output reg error_out,
  // image data stream
  input wire [7:0] image_data_in,
  input wire image_valid_in,
  output wire image_ready_out,
  // device pins
  output reg sclk_out,
  output reg mosi_out,
  output reg chip_select_n_out,
  output reg dev_reset_n_out,
  input wire miso_in
);

  localparam integer MISO_N = (MISO_WAIT_US * 1000) / `SBFP_CLK_NS;
  // timeout count cut to the timer width on purpose
  localparam [15:0] MISO_CYC = MISO_N[15:0];

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_RST = 4'h1;
  localparam [3:0] ST_RWAIT = 4'h2;
  localparam [3:0] ST_CSLO = 4'h3;
  localparam [3:0] ST_SEND = 4'h4;
  localparam [3:0] ST_MISO = 4'h5;
  localparam [3:0] ST_GAP = 4'h6;
  localparam [3:0] ST_CSHI = 4'h7;
  localparam [3:0] ST_DONE = 4'h8;

  // frame length in bytes for each command
  function [10:0] flen;
    input [3:0] cmd;
    begin
      case (cmd)
        `SBFP_C_BOOT: flen = 11'h002;
        `SBFP_C_UNLOCK: flen = 11'h001;
        `SBFP_C_ERASE: flen = 11'h001;
        `SBFP_C_SETADDR: flen = 11'h003;
        `SBFP_C_WRITE: flen = `SBFP_PAGE_BYTES + 11'h003;
        `SBFP_C_PROG: flen = 11'h005;
        `SBFP_C_VERIFY: flen = 11'h005;
        `SBFP_C_RESTART: flen = 11'h001;
        `SBFP_C_STATUS: flen = 11'h003;
        default: flen = 11'h001;
      endcase
    end
  endfunction

  // header byte of a frame, by command and byte index; unused tail bytes are zero
  function [7:0] fbyte;
    input [3:0] cmd;
    input [2:0] idx;
    input [4:0] page;
    input [31:0] cnt;
    reg [15:0] fa;
    reg [15:0] ra;
    reg [15:0] pb;
    reg [39:0] hdr;
    begin
      fa = `SBFP_FLASH_BASE + {1'b0, page, 10'h000};
      ra = `SBFP_RAM_ADDR;
      pb = {5'h00, `SBFP_PAGE_BYTES};
      case (cmd)
        `SBFP_C_BOOT: hdr = {`SBFP_OP_BOOT0, `SBFP_OP_BOOT1, 24'h000000};
        `SBFP_C_UNLOCK: hdr = {`SBFP_OP_UNLOCK, 32'h00000000};
        `SBFP_C_ERASE: hdr = {`SBFP_OP_ERASE, 32'h00000000};
        `SBFP_C_SETADDR: hdr = {`SBFP_OP_SETADDR, ra, 16'h0000};
        `SBFP_C_WRITE: hdr = {`SBFP_OP_WRITE, pb, 16'h0000};
        `SBFP_C_PROG: hdr = {`SBFP_OP_PROG, ra, fa};
        `SBFP_C_VERIFY: hdr = {`SBFP_OP_VERIFY, cnt};
        `SBFP_C_RESTART: hdr = {`SBFP_OP_RESTART, 32'h00000000};
        `SBFP_C_STATUS: hdr = {`SBFP_OP_STATUS, 32'h00000000};
        default: hdr = 40'h0000000000;
      endcase
      // byte index past the header shifts in zeros
      hdr = hdr << {idx, 3'b000};
      fbyte = hdr[39:32];
    end
  endfunction

  reg [3:0] st_reg;
  reg [3:0] cmd_reg;
  reg [3:0] ret_reg;
  reg [10:0] idx_reg;
  reg [4:0] page_reg;
  reg [31:0] vcount_reg;
  reg [15:0] status_reg;
  reg [15:0] tmr_reg;
  reg [3:0] div_reg;
  reg miso_s1_reg;
  reg miso_s2_reg;
  reg eng_busy_reg;
  reg eng_phase_reg;
  reg [2:0] eng_bit_reg;
  reg [7:0] eng_tx_reg;
  reg [7:0] eng_rx_reg;
  reg [7:0] buf_data_reg [0:1];
  reg buf_wr_reg;
  reg buf_rd_reg;
  reg [1:0] buf_cnt_reg;

  // serial clock half-period tick from the divider
  wire tick = (div_reg == `SBFP_SPI_HALF - 4'h1);
  // two-entry image buffer handshake
  wire buf_valid = (buf_cnt_reg != 2'h0);
  wire buf_push = image_valid_in && image_ready_out;
  wire data_phase = (cmd_reg == `SBFP_C_WRITE) && (idx_reg >= 11'h003);
  wire [10:0] data_ofs = idx_reg - 11'h003;
  wire [7:0] tx_byte = data_phase ? buf_data_reg[buf_rd_reg] :
                       fbyte(cmd_reg, idx_reg[2:0], page_reg, vcount_reg);
  wire eng_start = (st_reg == ST_SEND) && (idx_reg != flen(cmd_reg)) && !eng_busy_reg &&
                   (!data_phase || buf_valid);
  wire buf_pop = eng_start && data_phase;
  wire eng_end = eng_busy_reg && tick && eng_phase_reg && (eng_bit_reg == 3'h7);
  wire needs_sw = (cmd_reg != `SBFP_C_SETADDR) && (cmd_reg != `SBFP_C_WRITE) &&
                  (cmd_reg != `SBFP_C_RESTART) && (cmd_reg != `SBFP_C_STATUS);
  wire miso_cmd = (cmd_reg == `SBFP_C_BOOT) || (cmd_reg == `SBFP_C_UNLOCK);

  assign image_ready_out = (buf_cnt_reg != 2'h2);
  assign busy_out = (st_reg != ST_IDLE) && (st_reg != ST_DONE);

  // divider, synchroniser and image buffer
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_reg <= 4'h0;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
      buf_data_reg[0] <= 8'h00;
      buf_data_reg[1] <= 8'h00;
      buf_wr_reg <= 1'b0;
      buf_rd_reg <= 1'b0;
      buf_cnt_reg <= 2'h0;
    end else begin
      div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      miso_s1_reg <= miso_in;
      miso_s2_reg <= miso_s1_reg;
      if (buf_push) begin
        buf_data_reg[buf_wr_reg] <= image_data_in;
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (buf_pop)
        buf_rd_reg <= ~buf_rd_reg;
      if (buf_push && !buf_pop)
        buf_cnt_reg <= buf_cnt_reg + 2'h1;
      else if (buf_pop && !buf_push)
        buf_cnt_reg <= buf_cnt_reg - 2'h1;
    end
  end

  // byte shifter: MOSI moves on the falling edge, MISO sampled on the rising
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      eng_busy_reg <= 1'b0;
      eng_phase_reg <= 1'b0;
      eng_bit_reg <= 3'h0;
      eng_tx_reg <= 8'h00;
      eng_rx_reg <= 8'h00;
      sclk_out <= 1'b0;
      mosi_out <= 1'b0;
    end else if (eng_start) begin
      eng_busy_reg <= 1'b1;
      eng_phase_reg <= 1'b0;
      eng_bit_reg <= 3'h0;
      eng_tx_reg <= {tx_byte[6:0], 1'b0};
      mosi_out <= tx_byte[7];
    end else if (eng_busy_reg && tick) begin
      if (!eng_phase_reg) begin
        sclk_out <= 1'b1;
        eng_rx_reg <= {eng_rx_reg[6:0], miso_s2_reg};
        eng_phase_reg <= 1'b1;
      end else begin
        sclk_out <= 1'b0;
        eng_phase_reg <= 1'b0;
        if (eng_bit_reg == 3'h7) begin
          eng_busy_reg <= 1'b0;
        end else begin
          eng_bit_reg <= eng_bit_reg + 3'h1;
          mosi_out <= eng_tx_reg[7];
          eng_tx_reg <= {eng_tx_reg[6:0], 1'b0};
        end
      end
    end
  end

  // command sequencer
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_reg <= ST_IDLE;
      cmd_reg <= `SBFP_C_BOOT;
      ret_reg <= `SBFP_C_BOOT;
      idx_reg <= 11'h000;
      page_reg <= 5'h00;
      vcount_reg <= 32'h00000000;
      status_reg <= 16'h0000;
      tmr_reg <= 16'h0000;
      chip_select_n_out <= 1'b1;
      dev_reset_n_out <= 1'b1;
      done_out <= 1'b0;
      error_out <= 1'b0;
    end else begin
      if (start_in)
        error_out <= 1'b0;
      if (eng_start)
        idx_reg <= idx_reg + 11'h001;
      if (eng_start && data_phase && page_reg == 5'h00 &&
          data_ofs >= `SBFP_CNT_OFS && data_ofs < `SBFP_CNT_OFS + 11'h004)
        vcount_reg <= {tx_byte, vcount_reg[31:8]};
      if (eng_end && cmd_reg == `SBFP_C_STATUS)
        status_reg <= {status_reg[7:0], eng_rx_reg};
      case (st_reg)
        ST_IDLE, ST_DONE: begin
          if (start_in) begin
            done_out <= 1'b0;
            tmr_reg <= 16'h0000;
            dev_reset_n_out <= 1'b0;
            st_reg <= ST_RST;
          end
        end
        ST_RST: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (tmr_reg >= `SBFP_RST_CYC - 16'h0001) begin
            dev_reset_n_out <= 1'b1;
            tmr_reg <= 16'h0000;
            st_reg <= ST_RWAIT;
          end
        end
        ST_RWAIT: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (tmr_reg >= `SBFP_RWAIT_CYC - 16'h0001) begin
            cmd_reg <= `SBFP_C_BOOT;
            page_reg <= 5'h00;
            st_reg <= ST_CSLO;
          end
        end
        ST_CSLO: begin
          chip_select_n_out <= 1'b0;
          idx_reg <= 11'h000;
          if (tick)
            st_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (idx_reg == flen(cmd_reg) && !eng_busy_reg) begin
            tmr_reg <= 16'h0000;
            st_reg <= miso_cmd ? ST_MISO : ST_GAP;
          end
        end
        ST_MISO: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (miso_s2_reg) begin
            tmr_reg <= 16'h0000;
            st_reg <= ST_GAP;
          end else if (tmr_reg >= MISO_CYC) begin
            error_out <= 1'b1;
            chip_select_n_out <= 1'b1;
            tmr_reg <= 16'h0000;
            dev_reset_n_out <= 1'b0;
            st_reg <= ST_RST;
          end
        end
        ST_GAP: begin
          tmr_reg <= tmr_reg + 16'h0001;
          if (tmr_reg >= `SBFP_GAP_CYC - 16'h0001) begin
            tmr_reg <= 16'h0000;
            st_reg <= ST_CSHI;
          end
        end
        ST_CSHI: begin
          chip_select_n_out <= 1'b1;
          tmr_reg <= tmr_reg + 16'h0001;
          // hold select high a full half period before the next frame
          if (tmr_reg >= `SBFP_CSHI_CYC) begin
            tmr_reg <= 16'h0000;
            st_reg <= ST_CSLO;
            if (cmd_reg == `SBFP_C_STATUS) begin
              if (status_reg == `SBFP_SW_OK) begin
                case (ret_reg)
                  `SBFP_C_BOOT: cmd_reg <= `SBFP_C_UNLOCK;
                  `SBFP_C_UNLOCK: cmd_reg <= `SBFP_C_ERASE;
                  `SBFP_C_ERASE: cmd_reg <= `SBFP_C_SETADDR;
                  `SBFP_C_PROG: begin
                    if (page_reg == `SBFP_LAST_PAGE) begin
                      cmd_reg <= `SBFP_C_VERIFY;
                    end else begin
                      page_reg <= page_reg + 5'h01;
                      cmd_reg <= `SBFP_C_SETADDR;
                    end
                  end
                  default: cmd_reg <= `SBFP_C_RESTART;
                endcase
              end else if (!(ret_reg == `SBFP_C_PROG && status_reg == `SBFP_SW_BUSY)) begin
                error_out <= 1'b1;
                dev_reset_n_out <= 1'b0;
                st_reg <= ST_RST;
              end
            end else if (needs_sw) begin
              ret_reg <= cmd_reg;
              cmd_reg <= `SBFP_C_STATUS;
            end else if (cmd_reg == `SBFP_C_SETADDR) begin
              cmd_reg <= `SBFP_C_WRITE;
            end else if (cmd_reg == `SBFP_C_WRITE) begin
              cmd_reg <= `SBFP_C_PROG;
            end else begin
              done_out <= 1'b1;
              st_reg <= ST_DONE;
            end
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

endmodule

// [tb/sbfp_programmer_properties.sv]
// port checker for the serial bootloader programmer
`timescale 1ns/100ps
module sbfp_programmer_properties #(
  parameter integer MISO_WAIT_US = 100
) (
  // clock and reset
  input logic mclk_in,
  input logic resetn_in,
  // control
  input logic start_in,
  input logic busy_out,
  input logic done_out,
  input logic error_out,
  // image stream
  input logic [7:0] image_data_in,
  input logic image_valid_in,
  input logic image_ready_out,
  // device pins
  input logic sclk_out,
  input logic mosi_out,
  input logic chip_select_n_out,
  input logic dev_reset_n_out,
  input logic miso_in
);
  logic [15:0] quiet_reg;
  logic [15:0] low_reg;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_frame_open; $fell(chip_select_n_out); endsequence
  sequence s_frame_close; $rose(chip_select_n_out); endsequence
  // quiet time since a clock edge or MISO rise, and device reset low time
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      quiet_reg <= 16'h0000;
      low_reg <= 16'h0000;
    end else begin
      quiet_reg <= ($changed(sclk_out) || $rose(miso_in)) ? 16'h0000 : quiet_reg + 16'h0001;
      low_reg <= dev_reset_n_out ? 16'h0000 : low_reg + 16'h0001;
    end
  end
  a_start_busy: assert property (start_in && !busy_out |=> busy_out)
    else $error("start not taken");
  a_mosi_fall: assert property (!chip_select_n_out && $changed(mosi_out) |-> !sclk_out)
    else $error("data moved with clock high");
  a_sclk_idle: assert property (chip_select_n_out |-> !sclk_out)
    else $error("clock high outside frame");
  a_frame_open: assert property (s_frame_open |-> !sclk_out [*8])
    else $error("clock too soon after select");
  a_cs_high: assert property (s_frame_close |-> chip_select_n_out [*8])
    else $error("select high too short");
  a_gap_miso: assert property (s_frame_close ##0 ($past(miso_in) && dev_reset_n_out)
    |-> quiet_reg >= 16'h00BE)
    else $error("status gap too short");
  a_reset_hold: assert property ($rose(dev_reset_n_out)
    |-> low_reg >= 16'h0063 && low_reg <= 16'h0065)
    else $error("device reset width wrong");
  a_error_busy: assert property ($rose(error_out) |-> busy_out)
    else $error("run stopped on error");
  a_error_reset: assert property ($rose(error_out) |-> ##[0:300] !dev_reset_n_out)
    else $error("no device reset after error");
  a_no_frame: assert property (!dev_reset_n_out |-> chip_select_n_out && !sclk_out)
    else $error("frame during device reset");
endmodule
bind sbfp_programmer sbfp_programmer_properties #(.MISO_WAIT_US(MISO_WAIT_US))
  i_sbfp_programmer_properties (.mclk_in(mclk_in), .resetn_in(resetn_in),
  .start_in(start_in), .busy_out(busy_out), .done_out(done_out), .error_out(error_out),
  .image_data_in(image_data_in), .image_valid_in(image_valid_in),
  .image_ready_out(image_ready_out), .sclk_out(sclk_out), .mosi_out(mosi_out),
  .chip_select_n_out(chip_select_n_out), .dev_reset_n_out(dev_reset_n_out), .miso_in(miso_in));

// [tb/sbfp_dev_model.sv]
// behavioural device side of the serial loader link
`timescale 1ns/100ps
`include "sbfp_defs.vh"
module sbfp_dev_model (
  // link pins
  input wire sclk_in,
  input wire mosi_in,
  input wire chip_select_n_in,
  input wire dev_reset_n_in,
  output reg miso_out,
  // bench settings
  input wire [15:0] status_word_in,
  input wire miso_hang_in,
  input wire [31:0] rise_delay_in
);
  reg [7:0] shift_reg;
  reg [7:0] op_reg;
  reg [7:0] log_mem [0:255];
  integer bit_cnt;
  integer log_cnt;
  initial begin
    miso_out = 1'b1;
    bit_cnt = 0;
    log_cnt = 0;
  end
  // new frame: MISO held low while the command comes in
  always @(negedge chip_select_n_in) begin
    bit_cnt = 0;
    miso_out = 1'b0;
  end
  // released line has no pull, so it shows the inverse of its last level
  always @(posedge chip_select_n_in) miso_out = ~miso_out;
  // sample on rising clock, log bytes, schedule the late MISO rise
  always @(posedge sclk_in) begin
    if (!chip_select_n_in && dev_reset_n_in) begin
      shift_reg = {shift_reg[6:0], mosi_in};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 8)
        op_reg = shift_reg;
      if (bit_cnt % 8 == 0 && (op_reg != `SBFP_OP_STATUS || bit_cnt == 8)) begin
        log_mem[log_cnt % 256] = shift_reg;
        log_cnt = log_cnt + 1;
      end
      // status refreshed at the rise, before select returns high
      if (!miso_hang_in && ((op_reg == `SBFP_OP_BOOT0 && bit_cnt == 16 &&
          shift_reg == `SBFP_OP_BOOT1) || (op_reg == `SBFP_OP_UNLOCK && bit_cnt == 8)))
        miso_out <= #(rise_delay_in) 1'b1;
    end
  end
  // status word MSB first, changed on the falling clock
  always @(negedge sclk_in) begin
    if (!chip_select_n_in && op_reg == `SBFP_OP_STATUS && bit_cnt >= 8 && bit_cnt < 24)
      miso_out = status_word_in[23 - bit_cnt];
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the serial bootloader programmer
`timescale 1ns/100ps
`include "sbfp_defs.vh"
module tb_top;
  reg mclk_in;
  reg resetn_in;
  reg start_in;
  reg [7:0] image_data;
  reg image_valid;
  reg [15:0] status_word;
  reg miso_hang;
  reg [31:0] rise_delay;
  reg [31:0] rnd;
  wire busy, done, error, image_ready, sclk, mosi, chip_select_n, dev_reset_n, miso;
  integer bad_count;
  integer check_count;
  integer k;
  reg [7:0] sent_q[$];
  sbfp_programmer #(.MISO_WAIT_US(2)) i_sbfp_programmer (.mclk_in(mclk_in),
    .resetn_in(resetn_in), .start_in(start_in), .busy_out(busy), .done_out(done),
    .error_out(error), .image_data_in(image_data), .image_valid_in(image_valid),
    .image_ready_out(image_ready), .sclk_out(sclk), .mosi_out(mosi),
    .chip_select_n_out(chip_select_n), .dev_reset_n_out(dev_reset_n), .miso_in(miso));
  sbfp_dev_model i_sbfp_dev_model (.sclk_in(sclk), .mosi_in(mosi),
    .chip_select_n_in(chip_select_n), .dev_reset_n_in(dev_reset_n), .miso_out(miso),
    .status_word_in(status_word), .miso_hang_in(miso_hang), .rise_delay_in(rise_delay));
  // clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // image source: a taken byte is logged and replaced by a fresh random one
  always @(posedge mclk_in) begin
    if (image_valid && image_ready) begin
      sent_q.push_back(image_data);
      #1 rnd = $urandom;
      image_data = rnd[7:0];
    end
  end
  // expected wire bytes: command headers, then the image bytes taken
  function [7:0] exp_byte(input integer idx);
    reg [15:0] ram;
    reg [15:0] len;
    begin
      ram = `SBFP_RAM_ADDR;
      len = {5'h00, `SBFP_PAGE_BYTES};
      case (idx)
        0: exp_byte = `SBFP_OP_BOOT0;
        1: exp_byte = `SBFP_OP_BOOT1;
        2, 4, 6: exp_byte = `SBFP_OP_STATUS;
        3: exp_byte = `SBFP_OP_UNLOCK;
        5: exp_byte = `SBFP_OP_ERASE;
        7: exp_byte = `SBFP_OP_SETADDR;
        8: exp_byte = ram[15:8];
        9: exp_byte = ram[7:0];
        10: exp_byte = `SBFP_OP_WRITE;
        11: exp_byte = len[15:8];
        12: exp_byte = len[7:0];
        default: exp_byte = sent_q[idx - 13];
      endcase
    end
  endfunction
  task check(input logic [15:0] got, input logic [15:0] exp, input [8*16-1:0] what);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %0s got %h want %h", $time, what, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // bounded wait for an error flag or for a number of logged bytes
  task wait_until(input integer n, input logic on_err);
    integer c;
    begin
      c = 0;
      while ((on_err ? error !== 1'b1 : i_sbfp_dev_model.log_cnt < n) && c < 20000) begin
        @(posedge mclk_in);
        c = c + 1;
      end
      if (c == 20000) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: wait ran out", $time);
        close_out;
      end
    end
  endtask
  task do_reset;
    begin
      #1 resetn_in = 1'b0;
      repeat (2) @(posedge mclk_in);
      #1 resetn_in = 1'b1;
      i_sbfp_dev_model.log_cnt = 0;
    end
  endtask
  task kick;
    begin
      @(posedge mclk_in);
      #1 start_in = 1'b1;
      @(posedge mclk_in);
      #1 start_in = 1'b0;
    end
  endtask
  // main sequence
  initial begin
    bad_count = 0;
    check_count = 0;
    resetn_in = 1'b0;
    start_in = 1'b0;
    image_data = 8'h00;
    image_valid = 1'b0;
    status_word = `SBFP_SW_OK;
    miso_hang = 1'b0;
    rise_delay = 32'h0000012C;
    rnd = $urandom(32'h484959BD);
    do_reset;
    check({8'h00, sclk, mosi, chip_select_n, dev_reset_n, done, error, busy, image_ready},
      16'h0031, "reset levels");
    $display("reset test done");
    // clean run up to the first page data, random MISO delay and data
    rnd = $urandom;
    rise_delay = 32'h00000032 + (rnd % 32'h000004B0);
    image_valid = 1'b1;
    kick;
    repeat (6) @(posedge mclk_in);
    check({15'h0000, image_ready}, 16'h0000, "buffer full");
    check(sent_q.size(), 16'h0002, "bytes held");
    wait_until(21, 1'b0);
    for (k = 0; k < 21; k = k + 1)
      check(i_sbfp_dev_model.log_mem[k], exp_byte(k), "wire byte");
    check({14'h0000, busy, error}, 16'h0002, "run state");
    $display("clean run test done");
    // wrong status word: error, device reset, restart from boot
    do_reset;
    image_valid = 1'b0;
    sent_q.delete();
    rnd = $urandom;
    status_word = rnd[15:0] | 16'h0001;
    kick;
    wait_until(0, 1'b1);
    check({15'h0000, busy}, 16'h0001, "busy on restart");
    status_word = `SBFP_SW_OK;
    i_sbfp_dev_model.log_cnt = 0;
    wait_until(3, 1'b0);
    for (k = 0; k < 3; k = k + 1)
      check(i_sbfp_dev_model.log_mem[k], exp_byte(k), "restart byte");
    $display("status error test done");
    // MISO never rises: timeout before any status read
    do_reset;
    miso_hang = 1'b1;
    kick;
    wait_until(0, 1'b1);
    check(i_sbfp_dev_model.log_cnt, 16'h0002, "bytes at abort");
    $display("timeout test done");
    close_out;
  end
endmodule
